// ### logic/jmpp_defs.vh
// Overview of operation
// - Four-bit instruction register picks which data register sits between serial in and out.
// - Code C selects one-bit reset register; chip held in reset while it holds one.
// - Reset instruction or reset register never resets the test port state machine.
// - After reset register clears, reset stays on for a clock-option dependent time-out.
// - Code 4 selects sixteen-bit enable register shifted from serial input in shift-data.
// - On update-data, programming mode is entered only on exact unlock pattern match.
// - Enable register clears on power-on reset; host clears it when leaving programming.
// - Code 5 selects fifteen-bit command register, shifting commands in and results out.
// - Capture-data loads prior result; shift-data moves it out as new command moves in.
// - Update-data applies command; each run-test/idle pass gives one execute clock.
// - Code 6 gives 2048-bit load chain via eight-bit shifter feeding the page buffer.
// - During page loading, update-data transfers nothing; only shift-data acts (capture-data here also restarts the byte walk).
// - Code 7 gives 2056-bit read chain; bytes fetched and shifted out without capture.
// - While page-read chain is selected, the serial data input is ignored.
// - Chip erase is three commands then polling; status bit in result reports completion.
// - Program write: enter-write, address high/low, data low/high loads with byte operands.
// - Data latched by three-command top-bit pulse; page committed by three-command pulse.
// - Program read: enter-read, address loads, three commands; low byte second, high third.
// - Data-memory write: enter, address, one data byte, latch, three-command write, poll.
// - Data-memory read entered by its own enter command before address loads.
// - Every shift register shifts its least significant bit in and out first.
`ifndef JMPP_DEFS_VH
`define JMPP_DEFS_VH
// ****************************************
// Instruction codes
// ****************************************
`define JMPP_IR_CHIP_RESET 4'hc
`define JMPP_IR_UNLOCK 4'h4
`define JMPP_IR_COMMAND 4'h5
`define JMPP_IR_PAGE_WRITE 4'h6
`define JMPP_IR_PAGE_READ 4'h7
`define JMPP_IR_BYPASS 4'hf
`define JMPP_IR_CAPTURE 4'h1
`define JMPP_UNLOCK_SIG 16'ha370
// ****************************************
// Register map and fields
// ****************************************
`define JMPP_OFS_CTRL 12'h000
`define JMPP_OFS_STATUS 12'h004
`define JMPP_OFS_CMD 12'h008
`define JMPP_CTRL_SLOW_BIT 0
`define JMPP_CTRL_EXIT_BIT 1
`define JMPP_CTRL_RESET 32'h00000000
// ****************************************
// Timing counts
// ****************************************
`define JMPP_TOUT_FAST 16'h0040
`define JMPP_TOUT_SLOW 16'h1000
`endif

// ### logic/jmpp_port.v
// Local design decisions: the register addresses and the APB register port.
`include "jmpp_defs.vh"
`default_nettype none
module jmpp_port #(
    parameter [15:0] TOUT_FAST = `JMPP_TOUT_FAST,
    parameter [15:0] TOUT_SLOW = `JMPP_TOUT_SLOW
) (
    input wire mclk,
    input wire arst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire tck,
    input wire tms,
    input wire tdi,
    output reg tdo,
    output reg tdo_oe,
    output reg chip_reset,
    output reg prog_mode,
    output reg [14:0] mem_cmd,
    output reg mem_exec,
    input wire [14:0] mem_result,
    output reg [7:0] page_wr_data,
    output reg [7:0] page_wr_index,
    output reg page_wr_strobe,
    output reg [7:0] page_rd_index,
    input wire [7:0] page_rd_data
);

// ****************************************
// TAP states
// ****************************************
localparam [3:0] TLR = 4'd0;
localparam [3:0] RTI = 4'd1;
localparam [3:0] SELDR = 4'd2;
localparam [3:0] CAPDR = 4'd3;
localparam [3:0] SHDR = 4'd4;
localparam [3:0] EX1DR = 4'd5;
localparam [3:0] PSDR = 4'd6;
localparam [3:0] EX2DR = 4'd7;
localparam [3:0] UPDR = 4'd8;
localparam [3:0] SELIR = 4'd9;
localparam [3:0] CAPIR = 4'd10;
localparam [3:0] SHIR = 4'd11;
localparam [3:0] EX1IR = 4'd12;
localparam [3:0] PSIR = 4'd13;
localparam [3:0] EX2IR = 4'd14;
localparam [3:0] UPIR = 4'd15;

// ****************************************
// Pin synchronisers
// ****************************************
reg [1:0] tck_sync;
reg [1:0] tms_sync;
reg [1:0] tdi_sync;
reg tck_prev;
wire tck_rise;
wire tck_fall;
wire tms_s;
wire tdi_s;

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        tck_sync <= 2'b00;
        tms_sync <= 2'b11;
        tdi_sync <= 2'b00;
        tck_prev <= 1'b0;
    end else begin
        tck_sync <= {tck_sync[0], tck};
        tms_sync <= {tms_sync[0], tms};
        tdi_sync <= {tdi_sync[0], tdi};
        tck_prev <= tck_sync[1];
    end
end

assign tck_rise = tck_sync[1] & ~tck_prev;
assign tck_fall = ~tck_sync[1] & tck_prev;
assign tms_s = tms_sync[1];
assign tdi_s = tdi_sync[1];

// ****************************************
// TAP controller
// ****************************************
reg [3:0] tap;
reg [3:0] next_tap;

always @* begin
    case (tap)
        TLR: next_tap = tms_s ? TLR : RTI;
        RTI: next_tap = tms_s ? SELDR : RTI;
        SELDR: next_tap = tms_s ? SELIR : CAPDR;
        CAPDR: next_tap = tms_s ? EX1DR : SHDR;
        SHDR: next_tap = tms_s ? EX1DR : SHDR;
        EX1DR: next_tap = tms_s ? UPDR : PSDR;
        PSDR: next_tap = tms_s ? EX2DR : PSDR;
        EX2DR: next_tap = tms_s ? UPDR : SHDR;
        UPDR: next_tap = tms_s ? SELDR : RTI;
        SELIR: next_tap = tms_s ? TLR : CAPIR;
        CAPIR: next_tap = tms_s ? EX1IR : SHIR;
        SHIR: next_tap = tms_s ? EX1IR : SHIR;
        EX1IR: next_tap = tms_s ? UPIR : PSIR;
        PSIR: next_tap = tms_s ? EX2IR : PSIR;
        EX2IR: next_tap = tms_s ? UPIR : SHIR;
        UPIR: next_tap = tms_s ? SELDR : RTI;
        default: next_tap = TLR;
    endcase
end

// Only the pin TMS sequence and arst_n move the TAP
always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        tap <= TLR;
    end else if (tck_rise) begin
        tap <= next_tap;
    end
end

// ****************************************
// Instruction register
// ****************************************
reg [3:0] ir;
reg [3:0] ir_sh;

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        ir <= `JMPP_IR_BYPASS;
        ir_sh <= 4'h0;
    end else if (tck_rise) begin
        case (tap)
            TLR: ir <= `JMPP_IR_BYPASS;
            CAPIR: ir_sh <= `JMPP_IR_CAPTURE;
            SHIR: ir_sh <= {tdi_s, ir_sh[3:1]};
            UPIR: ir <= ir_sh;
            default: ir <= ir;
        endcase
    end
end

wire dr_cap = tck_rise & (tap == CAPDR);
wire dr_shift = tck_rise & (tap == SHDR);
wire dr_upd = tck_rise & (tap == UPDR);
wire sel_rst = (ir == `JMPP_IR_CHIP_RESET);
wire sel_unl = (ir == `JMPP_IR_UNLOCK);
wire sel_cmd = (ir == `JMPP_IR_COMMAND);
wire sel_pw = (ir == `JMPP_IR_PAGE_WRITE);
wire sel_pr = (ir == `JMPP_IR_PAGE_READ);

// ****************************************
// APB control register
// ****************************************
localparam [31:0] CTRL_RST = `JMPP_CTRL_RESET;
reg ctrl_slow;
wire apb_acc = psel & penable & pready;
wire ctrl_wr = apb_acc & pwrite & (paddr == `JMPP_OFS_CTRL);
wire exit_req = ctrl_wr & pwdata[`JMPP_CTRL_EXIT_BIT];

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        ctrl_slow <= CTRL_RST[`JMPP_CTRL_SLOW_BIT];
    end else if (ctrl_wr) begin
        ctrl_slow <= pwdata[`JMPP_CTRL_SLOW_BIT];
    end
end

// ****************************************
// Bypass, reset and unlock registers
// ****************************************
reg byp;
reg rst_bit;
reg [15:0] unl_sh;

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        byp <= 1'b0;
        rst_bit <= 1'b0;
        unl_sh <= 16'h0000;
        prog_mode <= 1'b0;
    end else begin
        if (dr_cap) begin
            byp <= 1'b0;
        end else if (dr_shift) begin
            byp <= tdi_s;
        end
        if (dr_shift & sel_rst) begin
            rst_bit <= tdi_s;
        end
        if (dr_shift & sel_unl) begin
            unl_sh <= {tdi_s, unl_sh[15:1]};
        end else if (exit_req) begin
            unl_sh <= 16'h0000;
        end
        // Unlock on update wins over a software exit in the same cycle
        if (dr_upd & sel_unl) begin
            prog_mode <= (unl_sh == `JMPP_UNLOCK_SIG);
        end else if (exit_req) begin
            prog_mode <= 1'b0;
        end
    end
end

// ****************************************
// Chip reset with time-out
// ****************************************
reg rst_prev;
reg [15:0] tout_cnt;

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        rst_prev <= 1'b0;
        tout_cnt <= 16'h0000;
        chip_reset <= 1'b0;
    end else begin
        rst_prev <= rst_bit;
        if (rst_prev & ~rst_bit) begin
            tout_cnt <= ctrl_slow ? TOUT_SLOW : TOUT_FAST;
        end else if (rst_bit) begin
            tout_cnt <= 16'h0000;
        end else if (tout_cnt != 16'h0000) begin
            tout_cnt <= tout_cnt - 16'h0001;
        end
        // Follows the shifted bit at once, no update stage
        chip_reset <= rst_bit | rst_prev | (tout_cnt != 16'h0000);
    end
end

// ****************************************
// Command register
// ****************************************
reg [14:0] cmd_sh;

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        cmd_sh <= 15'h0000;
        mem_cmd <= 15'h0000;
        mem_exec <= 1'b0;
    end else begin
        mem_exec <= 1'b0;
        if (sel_cmd & prog_mode) begin
            if (dr_cap) begin
                cmd_sh <= mem_result;
            end else if (dr_shift) begin
                cmd_sh <= {tdi_s, cmd_sh[14:1]};
            end
            if (dr_upd) begin
                mem_cmd <= cmd_sh;
            end
            if (tck_rise & (tap == RTI)) begin
                mem_exec <= 1'b1;
            end
        end
    end
end

// ****************************************
// Page stream chains
// ****************************************
reg [7:0] pg_sh;
reg [2:0] pg_bit;
wire pg_on = prog_mode & (sel_pw | sel_pr);

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        pg_sh <= 8'h00;
        pg_bit <= 3'd0;
        page_wr_data <= 8'h00;
        page_wr_index <= 8'h00;
        page_wr_strobe <= 1'b0;
        page_rd_index <= 8'h00;
    end else begin
        page_wr_strobe <= 1'b0;
        if (pg_on & dr_cap) begin
            // Restart the byte walk; read chain starts with eight dummy bits
            pg_sh <= 8'h00;
            pg_bit <= 3'd0;
            page_wr_index <= 8'h00;
            page_rd_index <= 8'h00;
        end else if (pg_on & dr_shift) begin
            pg_bit <= pg_bit + 3'd1;
            if (sel_pw) begin
                pg_sh <= {tdi_s, pg_sh[7:1]};
                if (pg_bit == 3'd7) begin
                    page_wr_data <= {tdi_s, pg_sh[7:1]};
                    page_wr_strobe <= 1'b1;
                end
            end else if (pg_bit == 3'd7) begin
                pg_sh <= page_rd_data;
                page_rd_index <= page_rd_index + 8'h01;
            end else begin
                pg_sh <= {1'b0, pg_sh[7:1]};
            end
        end else if (page_wr_strobe) begin
            page_wr_index <= page_wr_index + 8'h01;
        end
    end
end

// ****************************************
// Serial output
// ****************************************
reg next_tdo;

always @* begin
    next_tdo = byp;
    if (tap == SHIR) begin
        next_tdo = ir_sh[0];
    end else if (sel_rst) begin
        next_tdo = rst_bit;
    end else if (sel_unl) begin
        next_tdo = unl_sh[0];
    end else if (sel_cmd) begin
        next_tdo = cmd_sh[0];
    end else if (sel_pw | sel_pr) begin
        next_tdo = pg_sh[0];
    end
end

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        tdo <= 1'b0;
        tdo_oe <= 1'b0;
    end else if (tck_fall) begin
        tdo <= next_tdo;
        tdo_oe <= (tap == SHDR) | (tap == SHIR);
    end
end

// ****************************************
// APB slave
// ****************************************
reg [31:0] next_rdata;
reg next_err;

always @* begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    case (paddr)
        `JMPP_OFS_CTRL: next_rdata = {31'h00000000, ctrl_slow};
        `JMPP_OFS_STATUS: next_rdata = {20'h00000, tap, ir, 2'b00, chip_reset, prog_mode};
        `JMPP_OFS_CMD: next_rdata = {17'h00000, mem_cmd};
        default: next_err = 1'b1;
    endcase
end

always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
        pready <= 1'b0;
        prdata <= 32'h00000000;
        pslverr <= 1'b0;
    end else if (psel & penable & ~pready) begin
        pready <= 1'b1;
        prdata <= pwrite ? 32'h00000000 : next_rdata;
        pslverr <= next_err;
    end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
    end
end

endmodule
`default_nettype wire

// ### dv/jmpp_port_props.sv
`default_nettype none
// ****
// Port checker
// ****
module jmpp_port_props (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic chip_reset,
    input wire logic prog_mode,
    input wire logic [14:0] mem_cmd,
    input wire logic mem_exec,
    input wire logic [7:0] page_wr_index,
    input wire logic page_wr_strobe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence apb_answer;
        !pready ##1 pready;
    endsequence
    sequence strobe_quiet;
        !page_wr_strobe [*8];
    endsequence
    AST_APB_WAIT:
        assert property (apb_setup |=> apb_answer) else $error("apb answer out of step");
    AST_APB_PULSE:
        assert property (pready |=> !pready) else $error("pready held too long");
    AST_APB_ERR:
        assert property (pslverr |-> pready) else $error("pslverr without pready");
    AST_POR_LOCKED:
        assert property ($rose(arst_n) |-> !prog_mode && !chip_reset) else $error("locked state not cleared");
    AST_EXEC_PULSE:
        assert property (mem_exec |=> !mem_exec) else $error("execute pulse too long");
    AST_EXEC_GATED:
        assert property (mem_exec |-> $past(prog_mode)) else $error("execute while locked");
    AST_CMD_GATED:
        assert property (!$stable(mem_cmd) |-> $past(prog_mode)) else $error("command applied while locked");
    AST_STROBE_STEP:
        assert property (page_wr_strobe |=> page_wr_index == $past(page_wr_index) + 8'h01)
        else $error("page index did not step");
    AST_STROBE_GAP:
        assert property (page_wr_strobe |=> strobe_quiet) else $error("page bytes too close");
    AST_STROBE_GATED:
        assert property (page_wr_strobe |-> $past(prog_mode)) else $error("page write while locked");
endmodule
bind jmpp_port jmpp_port_props u_props (
    .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .chip_reset(chip_reset), .prog_mode(prog_mode), .mem_cmd(mem_cmd),
    .mem_exec(mem_exec), .page_wr_index(page_wr_index), .page_wr_strobe(page_wr_strobe)
);
`default_nettype wire

// ### dv/jmpp_host.sv
`default_nettype none
// ****
// Test port host
// ****
module jmpp_host (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // Pin changes kept clear of mclk edges; low phase lets the synchronised tdo settle
    task automatic step(input logic m, input logic d, output logic q);
        #10;
        tms = m;
        tdi = d;
        #230;
        tck = 1'b1;
        q = tdo;
        #150;
        tck = 1'b0;
        #10;
    endtask
    task automatic idle(input int k);
        logic q;
        repeat (k) step(1'b0, ~tdi, q);
    endtask
    // From idle through capture and shift back to idle; unused tdi toggles
    task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
        logic q;
        dout = '0;
        step(1'b1, ~tdi, q);
        if (ir) step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
        step(1'b0, ~tdi, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
    endtask
endmodule
`default_nettype wire

// ### dv/jtag_memory_programming_port_tb.sv
`include "jmpp_defs.vh"
`default_nettype none
module jtag_memory_programming_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam [15:0] TF = 16'h0064;
    localparam [15:0] TS = 16'h012c;
    localparam logic [14:0] CMDS [0:23] = '{15'h2380, 15'h3180, 15'h3380, 15'h3380, 15'h2310, 15'h0700,
        15'h0300, 15'h1300, 15'h1700, 15'h3700, 15'h7700, 15'h3700, 15'h3500, 15'h2302, 15'h0700,
        15'h0300, 15'h3200, 15'h3600, 15'h3700, 15'h2311, 15'h1300, 15'h3300, 15'h3100, 15'h2303};
    logic mclk, tck, tms, tdi, tdo, pready, pslverr, chip_reset, prog_mode, mem_exec, page_wr_strobe;
    logic arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [14:0] mem_result = 15'h0, mem_cmd;
    logic [7:0] page_wr_data, page_wr_index, page_rd_index, page_rd_data;
    logic tdo_oe, apb_err;
    int err_count, check_count, n_exec, n_oe;
    logic [7:0] got_q[$];
    jmpp_port #(.TOUT_FAST(TF), .TOUT_SLOW(TS)) u_dut (
        .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .chip_reset(chip_reset), .prog_mode(prog_mode),
        .mem_cmd(mem_cmd), .mem_exec(mem_exec), .mem_result(mem_result), .page_wr_data(page_wr_data),
        .page_wr_index(page_wr_index), .page_wr_strobe(page_wr_strobe), .page_rd_index(page_rd_index),
        .page_rd_data(page_rd_data)
    );
    jmpp_host u_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always_comb page_rd_data = page_rd_index ^ 8'h5a;
    always @(posedge mclk) begin
        if (mem_exec) n_exec <= n_exec + 1;
        if (tdo_oe) n_oe <= n_oe + 1;
        if (page_wr_strobe) got_q.push_back(page_wr_data);
    end
    // ****
    // Checks and bus tasks
    // ****
    task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask
    task automatic check_range(input int v, input int lo, input int hi);
        check_count++;
        if (v < lo || v > hi) begin
            err_count++;
            $display("unexpected at %0t: count %0d", $time, v);
        end
    endtask
    task automatic print_verdict;
        if (err_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        r = prdata;
        apb_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic set_ir(input logic [3:0] c);
        logic [63:0] o;
        u_host.scan(1'b1, 4, {60'h0, c}, o);
        check_val(o[3:0], 4'h1);
    endtask
    task automatic send(input logic [14:0] c, input logic [14:0] r, input int k, output logic [14:0] g);
        logic [63:0] o;
        int n0;
        int o0;
        @(posedge mclk);
        mem_result <= r;
        o0 = n_oe;
        u_host.scan(1'b0, 15, {49'h0, c}, o);
        g = o[14:0];
        check_val(g, r);
        check_range(n_oe - o0, 119, 121);
        repeat (6) @(posedge mclk);
        check_val(mem_cmd, c);
        n0 = n_exec;
        u_host.idle(k);
        repeat (6) @(posedge mclk);
        check_val(n_exec - n0, k);
    endtask
    initial begin
        #2000000;
        err_count++;
        print_verdict();
    end
    initial begin
        logic [31:0] s;
        logic [63:0] o, exp;
        logic [14:0] c, g;
        int t;
        void'($urandom(32'h6a41));
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        check_val({chip_reset, prog_mode}, 2'b00);
        apb(1'b0, `JMPP_OFS_STATUS, 32'h0, s);
        check_val(s[11:0], 12'h0f0);
        apb(1'b0, 12'h00c, 32'h0, s);
        check_val({apb_err, s}, 33'h100000000);
        u_host.idle(1);
        u_host.scan(1'b0, 4, 64'h6, o);
        check_val(o[3:0], 4'hc);
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, `JMPP_OFS_CTRL, 32'(m), s);
            set_ir(`JMPP_IR_CHIP_RESET);
            u_host.scan(1'b0, 1, 64'h1, o);
            check_val(chip_reset, 1'b1);
            apb(1'b0, `JMPP_OFS_STATUS, 32'h0, s);
            check_val(s[11:0], 12'h1c2);
            u_host.scan(1'b0, 1, 64'h0, o);
            t = 0;
            while (chip_reset === 1'b1 && t < 1000) begin
                @(posedge mclk);
                t++;
            end
            check_range(t, (m ? TS : TF) - 24, (m ? TS : TF) + 2);
        end
        u_host.scan(1'b0, 1, 64'h1, o);
        set_ir(`JMPP_IR_UNLOCK);
        for (int i = 0; i < 17; i++) begin
            exp = {48'h0, `JMPP_UNLOCK_SIG ^ (i < 16 ? 16'h1 << i : 16'h0)};
            u_host.scan(1'b0, 16, exp, o);
            repeat (4) @(posedge mclk);
            check_val(prog_mode, i == 16);
        end
        set_ir(`JMPP_IR_COMMAND);
        for (int i = 0; i < 24; i++) begin
            c = CMDS[i];
            if (c[14:8] inside {7'h07, 7'h03, 7'h13, 7'h17}) c[7:0] = 8'($urandom);
            send(c, 15'($urandom), 1 + $urandom % 3, g);
        end
        t = 0;
        do begin
            t++;
            send(15'h3700, (t > 2) ? 15'h0200 : 15'h0000, 1, g);
        end while (g[9] !== 1'b1 && t < 6);
        check_val(t, 3);
        set_ir(`JMPP_IR_PAGE_WRITE);
        exp = {$urandom, $urandom};
        got_q.delete();
        u_host.scan(1'b0, 32, exp, o);
        repeat (8) @(posedge mclk);
        check_val(got_q.size(), 4);
        foreach (got_q[i]) check_val(got_q[i], exp[8 * i +: 8]);
        set_ir(`JMPP_IR_PAGE_READ);
        u_host.scan(1'b0, 40, {$urandom, $urandom}, o);
        exp = 64'h0;
        for (int i = 0; i < 4; i++) exp[8 + 8 * i +: 8] = 8'(i) ^ 8'h5a;
        check_val(o[39:0], exp[39:0]);
        apb(1'b1, `JMPP_OFS_CTRL, 32'h2, s);
        apb(1'b0, `JMPP_OFS_CTRL, 32'h0, s);
        check_val({prog_mode, s}, 33'h0);
        set_ir(`JMPP_IR_COMMAND);
        u_host.scan(1'b0, 15, 64'h2311, o);
        repeat (6) @(posedge mclk);
        check_val(mem_cmd, 15'h3700);
        print_verdict();
    end
endmodule
`default_nettype wire
